// File: mrt_consts.svh
// Constants of the coprocessor repeat and trap control block
// Function
// - 13-bit repeat count, up to 8192 executions
// - Nonzero immediate repeat loads count as value minus one
// - Count N gives N plus one executions
// - Test zero each pass, else decrement, reissue
// - Repeat-active flag clears on final execution or by software write
// - Interrupt suspends repeat, resumes with remaining count
// - While suspended, flag and count hold unless software writes the word
// - Requests only with global enable set
// - Each status flag requests only when masked in
// - Request sets pending flag; software clears it
// - Class B trap Ah, priority I, flag bit 6
// - Flags update in execute; vector after 3 cycles
// - Stacked return pointer skips the causing instruction
// - Two's complement; unsigned per operand on multiply
// - Fraction format when fraction shift mode set
// - Round adds at bit 15, clears low word
// - Fraction mode shifts product left by one
// - Saturation limit flag sticky until software clears
`ifndef MRT_CONSTS_SVH
`define MRT_CONSTS_SVH
// Repeat control word layout
`define MRT_CNT_MSB 12
`define MRT_RA_BIT 15
`define MRT_RW_RESET 16'h0000
// Status word layout
`define MRT_ST_C 9
`define MRT_ST_SV 10
`define MRT_ST_E 11
`define MRT_ST_SL 12
`define MRT_ST_MIR 13
`define MRT_ST_RESET 16'h0000
// Control word layout
`define MRT_CT_CM 0
`define MRT_CT_VM 1
`define MRT_CT_EM 2
`define MRT_CT_LM 3
`define MRT_CT_MS 8
`define MRT_CT_MP 9
`define MRT_CT_MIE 15
`define MRT_CT_RESET 16'h0000
// Trap identity and timing
`define MRT_TFR_BIT 6
`define MRT_TRAP_NUM 8'h0a
`define MRT_TRAP_PRIO 2'h1
`define MRT_INSTR_CLKS 1
`define MRT_VEC_CYC (3 * `MRT_INSTR_CLKS)
// Accumulator constants
`define MRT_RND_ADD 40'h0000008000
`define MRT_LOW_MASK 40'hffffff0000
`define MRT_SAT_POS 40'h007fffffff
`define MRT_SAT_NEG 40'hff80000000
`endif

// File: mrt_ctrl.sv
// Coprocessor repeat unit, status flags and class B trap request logic
`timescale 1ns/1ns
`default_nettype none
`include "mrt_consts.svh"
module mrt_ctrl (
	input wire logic clock, // System clock, 25 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic rw_wr, // Write repeat control word
	input wire logic [15:0] rw_wdata, // Repeat control word data
	input wire logic rep_imm_start, // Repeat by immediate value
	input wire logic [4:0] rep_imm, // Immediate repeat value
	input wire logic rep_cnt_start, // Repeat by stored count
	input wire logic exec_done, // Repeated instruction executed
	input wire logic irq_take, // Interrupt taken by pipeline
	input wire logic irq_return, // Interrupt routine returned
	input wire logic ctrl_wr, // Write control word
	input wire logic [15:0] ctrl_wdata, // Control word data
	input wire logic status_wr, // Write status word
	input wire logic [15:0] status_wdata, // Status word data
	input wire logic trap_flag_clr, // Software clears trap flag
	input wire logic [15:0] next_ip, // Pointer of next instruction
	input wire logic op_valid, // Multiply step request
	input wire logic [15:0] op_a, // First operand
	input wire logic [15:0] op_b, // Second operand
	input wire logic a_signed, // First operand signed
	input wire logic b_signed, // Second operand signed
	input wire logic accumulate, // Add to accumulator
	input wire logic round_req, // Round accumulator
	output logic [15:0] repeat_control_word, // Count and active flag
	output logic repeat_reissue, // Issue instruction again
	output logic repeat_done, // Final execution seen
	output logic [15:0] coproc_status_word, // Status word
	output logic [15:0] coproc_control_word, // Control word
	output logic trap_request, // Class B trap request pulse
	output logic [7:0] trap_number, // Trap number of request
	output logic coproc_trap_flag, // Trap flag register bit
	output logic vector_go, // First vector instruction enters
	output logic [15:0] stacked_ip, // Return pointer to stack
	output logic [39:0] accumulator // Accumulator
);
	mrt_pkg::mrt_state_s s; // Registered state
	mrt_pkg::mrt_state_s next_s; // Next state
	logic dp_fv; // Datapath flags fresh
	logic dp_c; // Datapath carry
	logic dp_v; // Datapath overflow
	logic dp_e; // Datapath extension
	logic dp_l; // Datapath saturation
	logic [3:0] flags; // Status flags as seen by masks
	logic [3:0] masks; // Mask bits of control word
	logic req; // Masked request level
	logic event_hit; // Request rising this cycle

	// Accumulator datapath
	mrt_mac_dp u_dp (
		.clock(clock),
		.rstn(rstn),
		.op_valid(op_valid),
		.op_a(op_a),
		.op_b(op_b),
		.a_signed(a_signed),
		.b_signed(b_signed),
		.accumulate(accumulate),
		.frac_mode(s.ctrl[`MRT_CT_MP]),
		.sat_enable(s.ctrl[`MRT_CT_MS]),
		.round_req(round_req),
		.acc(accumulator),
		.flag_valid(dp_fv),
		.flag_c(dp_c),
		.flag_v(dp_v),
		.flag_e(dp_e),
		.flag_l(dp_l)
	);

	// Request from registered flags and masks
	always_comb begin
		flags = {s.status[`MRT_ST_SL], s.status[`MRT_ST_E], s.status[`MRT_ST_SV],
			s.status[`MRT_ST_C]};
		masks = {s.ctrl[`MRT_CT_LM], s.ctrl[`MRT_CT_EM], s.ctrl[`MRT_CT_VM],
			s.ctrl[`MRT_CT_CM]};
		req = s.ctrl[`MRT_CT_MIE] & |(flags & masks);
		// Edge, so a standing flag does not trap again every cycle
		event_hit = req & ~s.req_prev;
	end

	// Next state
	always_comb begin
		next_s = s;
		next_s.trap_req = 1'b0;
		next_s.vec_go = 1'b0;
		next_s.reissue = 1'b0;
		next_s.done = 1'b0;
		next_s.trap_num = `MRT_TRAP_NUM;
		next_s.req_prev = req;
		if (ctrl_wr) begin
			next_s.ctrl = ctrl_wdata;
		end
		// Flags change in the execute stage, by write or by operation
		if (status_wr) begin
			next_s.status = status_wdata;
		end else if (s.dly == 2'h0 && 1'b1 && dp_fv) begin
			next_s.status[`MRT_ST_C] = dp_c;
			next_s.status[`MRT_ST_E] = dp_e;
			next_s.status[`MRT_ST_SV] = s.status[`MRT_ST_SV] | dp_v;
			next_s.status[`MRT_ST_SL] = s.status[`MRT_ST_SL] | dp_l;
		end else if (dp_fv) begin
			next_s.status[`MRT_ST_C] = dp_c;
			next_s.status[`MRT_ST_E] = dp_e;
			next_s.status[`MRT_ST_SV] = s.status[`MRT_ST_SV] | dp_v;
			next_s.status[`MRT_ST_SL] = s.status[`MRT_ST_SL] | dp_l;
		end
		// Trap flag: a new request beats a software clear
		if (trap_flag_clr) begin
			next_s.trap_flag = 1'b0;
		end
		if (event_hit) begin
			next_s.status[`MRT_ST_MIR] = 1'b1;
			next_s.trap_flag = 1'b1;
			next_s.trap_req = 1'b1;
			next_s.dly = 2'(`MRT_VEC_CYC);
		end else if (s.dly != 2'h0) begin
			// Count down the vector latency
			next_s.dly = s.dly - 2'h1;
			if (s.dly == 2'h1) begin
				next_s.vec_go = 1'b1;
				// Pipeline has moved on, so the causing one is not stacked
				next_s.stacked_ip = next_ip;
			end
		end
		// Software may write the word unless a sequence is issuing
		if (rw_wr && s.rep != mrt_pkg::rep_run) begin
			next_s.count = rw_wdata[`MRT_CNT_MSB:0];
			next_s.active = rw_wdata[`MRT_RA_BIT];
		end
		case (s.rep)
			mrt_pkg::rep_idle: begin
				if (rep_imm_start) begin
					// Zero immediate behaves as a single execution
					next_s.count = (rep_imm == 5'h0) ? 13'h0 : 13'({rep_imm} - 5'h1);
					next_s.active = 1'b1;
					next_s.rep = mrt_pkg::rep_run;
				end else if (rep_cnt_start) begin
					next_s.active = 1'b1;
					next_s.rep = mrt_pkg::rep_run;
				end
			end
			mrt_pkg::rep_run: begin
				if (irq_take) begin
					// Stop issuing, keep count and flag for the return
					next_s.rep = mrt_pkg::rep_susp;
				end else if (exec_done) begin
					if (s.count == 13'h0) begin
						// Final execution ends the sequence
						next_s.active = 1'b0;
						next_s.done = 1'b1;
						next_s.rep = mrt_pkg::rep_idle;
					end else begin
						next_s.count = s.count - 13'h1;
						next_s.reissue = 1'b1;
					end
				end
			end
			mrt_pkg::rep_susp: begin
				if (irq_return) begin
					next_s.rep = mrt_pkg::rep_run;
				end
			end
			default: begin
				next_s.rep = mrt_pkg::rep_idle;
			end
		endcase
	end

	// Register the state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign repeat_control_word = {s.active, 2'b00, s.count};
	assign repeat_reissue = s.reissue;
	assign repeat_done = s.done;
	assign coproc_status_word = s.status;
	assign coproc_control_word = s.ctrl;
	assign trap_request = s.trap_req;
	assign trap_number = s.trap_num;
	assign coproc_trap_flag = s.trap_flag;
	assign vector_go = s.vec_go;
	assign stacked_ip = s.stacked_ip;

	// Immediate start loads value minus one
	a_imm_load: assert property (@(posedge clock) disable iff (!rstn)
		s.rep == mrt_pkg::rep_idle && rep_imm_start && rep_imm != 5'h0
		|=> s.count == 13'($past(rep_imm) - 5'h1) && s.active)
		else $error("immediate repeat count wrong");
	// Non-final execution decrements and reissues
	a_count_dec: assert property (@(posedge clock) disable iff (!rstn)
		s.rep == mrt_pkg::rep_run && !irq_take && exec_done && s.count != 13'h0
		|=> s.count == $past(s.count) - 13'h1 && repeat_reissue)
		else $error("repeat count not decremented");
	// Final execution clears the flag
	a_last_done: assert property (@(posedge clock) disable iff (!rstn)
		s.rep == mrt_pkg::rep_run && !irq_take && exec_done && s.count == 13'h0
		|=> !s.active && repeat_done && !repeat_reissue)
		else $error("final execution not closed");
	// Interrupt stops the sequence
	a_irq_stop: assert property (@(posedge clock) disable iff (!rstn)
		s.rep == mrt_pkg::rep_run && irq_take
		|=> s.rep == mrt_pkg::rep_susp && !repeat_reissue)
		else $error("interrupt did not suspend repeat");
	// Suspended sequence holds count and flag
	a_susp_hold: assert property (@(posedge clock) disable iff (!rstn)
		s.rep == mrt_pkg::rep_susp && !rw_wr
		|=> $stable(s.count) && $stable(s.active))
		else $error("suspended repeat changed");
	// No request without global enable
	a_gate_off: assert property (@(posedge clock) disable iff (!rstn)
		!s.ctrl[`MRT_CT_MIE] |=> !trap_request)
		else $error("request without global enable");
	// Request needs a flag with its mask
	a_mask_gate: assert property (@(posedge clock) disable iff (!rstn)
		trap_request |-> $past(|(flags & masks)))
		else $error("request without masked flag");
	// Request sets pending and trap flag
	a_pend_set: assert property (@(posedge clock) disable iff (!rstn)
		trap_request |-> s.status[`MRT_ST_MIR] && coproc_trap_flag
		&& trap_number == `MRT_TRAP_NUM)
		else $error("pending or trap flag not set");
	// Vector enters three cycles after request
	a_vec_lat: assert property (@(posedge clock) disable iff (!rstn)
		trap_request |-> !vector_go [*3] ##1 vector_go)
		else $error("vector latency wrong");
	// Return pointer taken with the vector
	a_ip_stack: assert property (@(posedge clock) disable iff (!rstn)
		vector_go |-> stacked_ip == $past(next_ip))
		else $error("stacked pointer wrong");
	// Limit flag stays until written
	a_sl_sticky: assert property (@(posedge clock) disable iff (!rstn)
		s.status[`MRT_ST_SL] && !status_wr |=> s.status[`MRT_ST_SL])
		else $error("limit flag dropped");

	cv_full_repeat: cover property (@(posedge clock) disable iff (!rstn)
		rep_imm_start ##[1:40] repeat_done);
	cv_suspend_resume: cover property (@(posedge clock) disable iff (!rstn)
		s.rep == mrt_pkg::rep_susp ##[1:20] s.rep == mrt_pkg::rep_run);
	cv_trap: cover property (@(posedge clock) disable iff (!rstn)
		trap_request ##3 vector_go);
endmodule : mrt_ctrl
`default_nettype wire

// File: mrt_mac_dp.sv
// Multiply-accumulate datapath: products, accumulation, rounding, flags
`timescale 1ns/1ns
`default_nettype none
`include "mrt_consts.svh"
module mrt_mac_dp (
	input wire logic clock, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic op_valid, // Multiply step request
	input wire logic [15:0] op_a, // First operand
	input wire logic [15:0] op_b, // Second operand
	input wire logic a_signed, // First operand signed
	input wire logic b_signed, // Second operand signed
	input wire logic accumulate, // Add to accumulator, else load
	input wire logic frac_mode, // Fraction shift mode
	input wire logic sat_enable, // Automatic saturation
	input wire logic round_req, // Round accumulator
	output logic [39:0] acc, // Accumulator
	output logic flag_valid, // Flags below are fresh
	output logic flag_c, // Carry out
	output logic flag_v, // 40-bit overflow
	output logic flag_e, // Extension in use
	output logic flag_l // Saturation applied
);
	mrt_pkg::mrt_dp_s s; // Registered state
	mrt_pkg::mrt_dp_s next_s; // Next state

	// Widen an operand by its signedness bit
	function automatic logic [16:0] ext17(input logic [15:0] x, input logic sgn);
		ext17 = {sgn & x[15], x};
	endfunction : ext17

	// Compute the next accumulator and flags
	always_comb begin
		logic signed [33:0] prod;
		logic [39:0] addend;
		logic [40:0] sum;
		prod = $signed(ext17(op_a, a_signed)) * $signed(ext17(op_b, b_signed));
		addend = {{8{prod[31]}}, prod[31:0]};
		if (frac_mode) begin
			addend = {addend[38:0], 1'b0}; // Drops the doubled sign bit
		end
		sum = 41'h0;
		next_s = s;
		next_s.fv = 1'b0;
		if (round_req) begin
			// Round takes priority over a multiply step
			sum = {1'b0, s.acc} + {1'b0, `MRT_RND_ADD};
			next_s.acc = sum[39:0] & `MRT_LOW_MASK;
		end else if (op_valid) begin
			if (!accumulate) begin
				sum = {1'b0, addend};
			end else begin
				sum = {1'b0, s.acc} + {1'b0, addend};
			end
			next_s.acc = sum[39:0];
			next_s.fv = 1'b1;
			next_s.c = sum[40];
			next_s.v = accumulate & (s.acc[39] == addend[39]) & (sum[39] != s.acc[39]);
			next_s.e = ~(&sum[39:31] | ~|sum[39:31]);
			next_s.l = 1'b0;
			// Saturation clamps to 32 bits; the extension no longer holds bits
			if (sat_enable && next_s.e) begin
				next_s.acc = sum[39] ? `MRT_SAT_NEG : `MRT_SAT_POS;
				next_s.l = 1'b1;
				next_s.e = 1'b0;
			end
		end
	end

	// Register the state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign acc = s.acc;
	assign flag_valid = s.fv;
	assign flag_c = s.c;
	assign flag_v = s.v;
	assign flag_e = s.e;
	assign flag_l = s.l;

	// Rounding leaves the low word clear
	a_round_low_clear: assert property (@(posedge clock) disable iff (!rstn)
		round_req |=> acc[15:0] == 16'h0)
		else $error("low word not cleared after round");
	// Fraction mode doubles a loaded product
	a_frac_shift: assert property (@(posedge clock) disable iff (!rstn)
		op_valid && !round_req && !accumulate && frac_mode && !sat_enable
		|=> acc[0] == 1'b0)
		else $error("fraction product not shifted");
	cv_round: cover property (@(posedge clock) disable iff (!rstn) round_req);
endmodule : mrt_mac_dp
`default_nettype wire

// File: mrt_pipe_model.sv
// Behavioural model of the CPU pipeline that issues the repeated instruction
`timescale 1ns/1ns
`default_nettype none
module mrt_pipe_model (
	input wire logic clock, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic [15:0] rcw, // Repeat control word
	input wire logic reissue, // Issue again
	input wire logic done, // Final execution seen
	input wire logic hold, // Interrupt routine running
	input wire logic [3:0] slow, // Stall cycles between executions
	output logic exec_done, // One execution finished
	output logic [15:0] execs // Executions issued so far
);
	logic busy; // Waiting for the block to answer
	logic [3:0] gap; // Stall cycles left
	// One execution per answer, so no extra one slips past the last
	always_ff @(negedge clock or negedge rstn) begin
		if (!rstn) begin
			exec_done <= 1'b0;
			busy <= 1'b0;
			gap <= 4'h0;
			execs <= 16'h0000;
		end else if (busy) begin
			exec_done <= 1'b0;
			if (reissue || done) begin
				busy <= 1'b0;
				gap <= slow;
			end
		end else if (gap != 4'h0) begin
			gap <= gap - 4'h1;
		end else if (rcw[15] && !hold) begin
			exec_done <= 1'b1;
			busy <= 1'b1;
			execs <= execs + 16'h0001;
		end
	end
endmodule : mrt_pipe_model
`default_nettype wire

// File: mrt_pkg.sv
// Types shared by the coprocessor repeat and trap control block
package mrt_pkg;
	// Repeat unit sequence state
	typedef enum logic [1:0] {
		rep_idle = 2'b00, // No sequence
		rep_run = 2'b01, // Issuing iterations
		rep_susp = 2'b10 // Held by an interrupt
	} mrt_rep_e;
	// Whole state of the control module
	typedef struct packed {
		mrt_rep_e rep; // Repeat sequence state
		logic [12:0] count; // Repeat count
		logic active; // Repeat-active flag
		logic [15:0] status; // Status word
		logic [15:0] ctrl; // Control word
		logic trap_flag; // Trap flag bit
		logic req_prev; // Request level last cycle
		logic [1:0] dly; // Vector latency counter
		logic trap_req; // Trap request pulse
		logic vec_go; // Vector fetch pulse
		logic [15:0] stacked_ip; // Return pointer
		logic reissue; // Issue again pulse
		logic done; // Sequence finished pulse
		logic [7:0] trap_num; // Trap number
	} mrt_state_s;
	// Whole state of the accumulator datapath
	typedef struct packed {
		logic [39:0] acc; // Accumulator
		logic fv; // Flag set valid
		logic c; // Carry
		logic v; // 40-bit overflow
		logic e; // Extension
		logic l; // Saturation happened
	} mrt_dp_s;
endpackage : mrt_pkg

// File: test_mrt_ctrl.sv
// Self-checking testbench of the repeat and trap control block
`timescale 1ns/1ns
`default_nettype none
module test_mrt_ctrl;
	logic clock = 1'b0; // 25 MHz clock
	logic rstn = 1'b0; // Reset, active low
	logic rw_wr, rep_imm_start, rep_cnt_start, irq_take, irq_return, ctrl_wr, status_wr;
	logic trap_flag_clr, op_valid, a_signed, b_signed, accumulate, round_req, hold;
	logic [15:0] rw_wdata, ctrl_wdata, status_wdata, op_a, op_b, rcw, sw, cw, sip, execs;
	logic [15:0] base, saved;
	logic [15:0] next_ip = 16'h0124; // Pointer after the causing instruction
	logic [4:0] rep_imm; // Immediate repeat value
	logic [3:0] slow; // Model stall
	logic exec_done, reissue, done, tp, tf, vg; // Handshakes
	logic [7:0] tn; // Trap number
	logic [39:0] acc; // Accumulator
	int fail_count, checks_done, n;
	int imms[3] = '{1, 3, 31}; // Immediate boundaries
	int cnts[2] = '{5, 8191}; // Stored counts, top one is the 13-bit maximum
	logic [15:0] bad_ct[2] = '{16'h000f, 16'h8001}; // Global enable off, wrong mask
	logic [15:0] bad_st[2] = '{16'h1e00, 16'h0400};
	mrt_ctrl dut_u (.clock(clock), .rstn(rstn), .rw_wr(rw_wr), .rw_wdata(rw_wdata),
		.rep_imm_start(rep_imm_start), .rep_imm(rep_imm), .rep_cnt_start(rep_cnt_start),
		.exec_done(exec_done), .irq_take(irq_take), .irq_return(irq_return),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .status_wr(status_wr),
		.status_wdata(status_wdata), .trap_flag_clr(trap_flag_clr), .next_ip(next_ip),
		.op_valid(op_valid), .op_a(op_a), .op_b(op_b), .a_signed(a_signed),
		.b_signed(b_signed), .accumulate(accumulate), .round_req(round_req),
		.repeat_control_word(rcw), .repeat_reissue(reissue), .repeat_done(done),
		.coproc_status_word(sw), .coproc_control_word(cw), .trap_request(tp),
		.trap_number(tn), .coproc_trap_flag(tf), .vector_go(vg), .stacked_ip(sip),
		.accumulator(acc));
	mrt_pipe_model pipe_u (.clock(clock), .rstn(rstn), .rcw(rcw), .reissue(reissue),
		.done(done), .hold(hold), .slow(slow), .exec_done(exec_done), .execs(execs));
	// Clock generator
	always #20 clock = ~clock;
	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask : cyc
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle word write: 0 repeat word, 1 control, 2 status
	task automatic wr(input int sel, input logic [15:0] d);
		cyc(1);
		rw_wdata = d;
		ctrl_wdata = d;
		status_wdata = d;
		rw_wr = (sel == 0);
		ctrl_wr = (sel == 1);
		status_wr = (sel == 2);
		cyc(1);
		{rw_wr, ctrl_wr, status_wr} = 3'b000;
	endtask : wr
	// One-cycle strobe, chosen by number
	task automatic pulse(input int sel);
		cyc(1);
		{rep_imm_start, rep_cnt_start, irq_take, irq_return, trap_flag_clr, round_req,
			op_valid} = 7'b1000000 >> sel;
		cyc(1);
		{rep_imm_start, rep_cnt_start, irq_take, irq_return, trap_flag_clr, round_req,
			op_valid} = 7'b0000000;
	endtask : pulse
	// Active flag must stand until the final execution, bounded wait
	task automatic wait_done();
		n = 0;
		do begin
			chk(rcw[15], !done);
			cyc(1);
			n++;
		end while (!done && n < 20000);
		chk(rcw[15], 1'b0);
	endtask : wait_done
	// Cycles until trap request (vec 0) or vector fetch (vec 1), 8 at most
	task automatic wait_sig(input bit vec, output int k);
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (!(vec ? vg : tp) && k < 8);
	endtask : wait_sig
	task automatic mul(input logic [15:0] a, input logic [15:0] b, input logic [1:0] sg,
		input logic [39:0] exp);
		op_a = a;
		op_b = b;
		{a_signed, b_signed} = sg;
		pulse(6);
		chk(acc, exp);
	endtask : mul
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// Watchdog: the longest sequence needs about 17000 cycles
	initial begin
		#1600000;
		fail_count++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		{rw_wr, rep_imm_start, rep_cnt_start, irq_take, irq_return, ctrl_wr, status_wr} = '0;
		{trap_flag_clr, op_valid, a_signed, b_signed, accumulate, round_req} = '0;
		{rw_wdata, ctrl_wdata, status_wdata, op_a, op_b, rep_imm} = '0;
		hold = 1'b0;
		slow = 4'h0;
		repeat (12) @(posedge clock);
		cyc(1);
		chk({rcw, sw, tn}, 40'h0);
		rstn = 1'b1;
		cyc(1);
		chk(tn, 8'h0a);
		foreach (imms[i]) begin
			slow <= (i == 1) ? 4'h3 : 4'h0;
			base = execs;
			rep_imm = imms[i][4:0];
			pulse(0);
			chk(rcw, {1'b1, 2'b00, 13'(imms[i] - 1)});
			wait_done();
			chk(execs - base, imms[i]);
		end
		foreach (cnts[i]) begin
			base = execs;
			wr(0, cnts[i][15:0]); // active flag written as zero
			chk(rcw, cnts[i]);
			cyc(1);
			pulse(1);
			wait_done();
			chk(execs - base, cnts[i] + 1);
		end
		slow <= 4'h3;
		base = execs;
		wr(0, 16'h000a);
		cyc(1);
		pulse(1);
		cyc(12);
		hold <= 1'b1;
		cyc(6);
		pulse(2);
		chk(rcw, {1'b1, 2'b00, 13'(16'd10 - (execs - base))});
		saved = rcw; // routine leaves the word alone
		cyc(20);
		chk(rcw, saved);
		pulse(3);
		hold <= 1'b0;
		wait_done();
		chk(execs - base, 11);
		for (int i = 0; i < 4; i++) begin
			wr(1, 16'h8000 | (16'h0001 << i));
			chk(cw, 16'h8000 | (16'h0001 << i));
			wr(2, 16'h0200 << i);
			// Flag stands after the write edge, request one edge later
			wait_sig(0, n);
			chk(n, 1);
			chk({sw[13], tf, tn}, 10'h30a);
			wait_sig(1, n);
			chk(n, 3);
			chk(sip, next_ip);
			wr(2, 16'h0000);
			pulse(4);
			chk({sw, tf}, 17'h0);
		end
		foreach (bad_ct[i]) begin
			wr(1, bad_ct[i]);
			wr(2, bad_st[i]);
			wait_sig(0, n);
			chk({n[3:0], sw[13]}, 5'h10);
			wr(2, 16'h0000);
		end
		wr(1, 16'h0000);
		mul(16'h0001, 16'h8000, 2'b00, 40'h0000008000);
		pulse(5);
		chk(acc, 40'h0000010000);
		mul(16'h7fff, 16'h0001, 2'b00, 40'h0000007fff);
		pulse(5);
		chk(acc, 40'h0);
		mul(16'hffff, 16'h0002, 2'b11, 40'hfffffffffe);
		mul(16'hffff, 16'h0002, 2'b01, 40'h000001fffe);
		wr(1, 16'h0200);
		mul(16'h4000, 16'h4000, 2'b11, 40'h0020000000);
		wr(1, 16'h0000);
		wr(2, 16'h1000);
		mul(16'h0001, 16'h0001, 2'b00, 40'h0000000001);
		cyc(2);
		chk(sw[12], 1'b1);
		report_and_stop();
	end
endmodule : test_mrt_ctrl
`default_nettype wire
